// ### rtl/wake_power_ctrl.sv
// operating mode and wake event controller of the reader transceiver
`timescale 1ns/1ps
module wake_power_ctrl
  import wake_ctrl_pkg::*;
#(
  parameter int unsigned SETUP_CYC = FAST_SETUP_CYC
) (
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  input  wire logic              wake_rx_i,
  input  wire logic              slave_sel_n_i,
  input  wire logic              iface_sel_bit0_i,
  input  wire logic              iface_sel_bit1_i,
  input  wire logic              tag_detected_i,
  input  wire logic              timer_expired_i,
  input  wire logic              idle_cmd_i,
  input  wire logic [1:0]        idle_target_i,
  input  wire logic [SRC_W-1:0]  idle_src_en_i,
  input  wire logic              air_standard_choose_cmd_i,
  input  wire logic              field_off_cmd_i,
  output logic [2:0]             state_o,
  output logic                   wait_event_group_o,
  output logic                   slow_oscillator_o,
  output logic                   fast_oscillator_o,
  output logic                   rf_field_on_o,
  output logic                   host_comm_en_o,
  output logic                   uart_rx_gate_o,
  output logic [1:0]             iface_o,
  output logic [SRC_W-1:0]       src_en_o
);
  localparam int unsigned SW = $clog2(SETUP_CYC + 1);

  logic [1:0]       rst_sync_ff;
  wire              rst_n = rst_sync_ff[1];
  logic [1:0]       wake_s_ff, ss_s_ff, sel0_s_ff, sel1_s_ff, tag_s_ff;
  logic             wake_prev_ff;
  pwr_state_t       state_ff, nxt_state;
  logic [SW-1:0]    setup_cnt_ff;
  logic [SRC_W-1:0] src_en_ff;
  logic             sel_pending_ff;
  logic             rf_on_ff;
  logic             uart_gate_ff;
  logic             wake_long;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  // wake, select, strap and tag pins pass two flops before use
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      wake_s_ff    <= 2'b11;
      ss_s_ff      <= 2'b11;
      sel0_s_ff    <= 2'b00;
      sel1_s_ff    <= 2'b00;
      tag_s_ff     <= 2'b00;
      wake_prev_ff <= 1'b1;
    end else begin
      wake_s_ff    <= {wake_s_ff[0], wake_rx_i};
      ss_s_ff      <= {ss_s_ff[0], slave_sel_n_i};
      sel0_s_ff    <= {sel0_s_ff[0], iface_sel_bit0_i};
      sel1_s_ff    <= {sel1_s_ff[0], iface_sel_bit1_i};
      tag_s_ff     <= {tag_s_ff[0], tag_detected_i};
      wake_prev_ff <= wake_s_ff[1];
    end
  end

  wire wake_low  = !wake_s_ff[1];
  wire wake_fall = wake_prev_ff && wake_low;
  wire ss_active = !ss_s_ff[1];

  wire in_wait_group = (state_ff == ST_POWER_UP) ||
                       (state_ff == ST_HIBERNATE) ||
                       (state_ff == ST_SLEEP) ||
                       (state_ff == ST_TAG_DETECT);
  wire slow_run = (state_ff == ST_POWER_UP) || (state_ff == ST_SLEEP) ||
                  (state_ff == ST_TAG_DETECT);
  wire qual_run = (state_ff == ST_POWER_UP) || (state_ff == ST_HIBERNATE);

  wake_pulse_qual #(
    .DIV   (SLOW_DIV),
    .TICKS (WAKE_MIN_TICKS)
  ) wake_pulse_qual_i (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n),
    .run_i       (qual_run),
    .wake_low_i  (wake_low),
    .slow_tick_o (),
    .wake_ok_o   (wake_long)
  );

  wire sleep_wake = (src_en_ff[SRC_TIMER] && timer_expired_i) ||
                    (src_en_ff[SRC_WAKE_PIN] && wake_low) ||
                    (src_en_ff[SRC_SEL_PIN] && ss_active);
  wire tag_wake   = sleep_wake || (src_en_ff[SRC_TAG] && tag_s_ff[1]);
  wire setup_done = (setup_cnt_ff == SW'(SETUP_CYC - 1));
  // only idle command enters low power
  wire idle_ok    = idle_cmd_i && host_comm_en_o;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POWER_UP:   if (wake_long) nxt_state = ST_OSC_SETUP;
      ST_HIBERNATE:  if (wake_long) nxt_state = ST_OSC_SETUP;
      // any valid wake goes to oscillator setup
      ST_SLEEP:      if (sleep_wake) nxt_state = ST_OSC_SETUP;
      ST_TAG_DETECT: if (tag_wake) nxt_state = ST_OSC_SETUP;
      ST_OSC_SETUP:  if (setup_done && !sel_pending_ff) nxt_state = ST_READY;
      ST_READY, ST_READER: begin
        if (idle_ok) begin
          case (idle_target_i)
            IDLE_HIBERNATE: nxt_state = ST_HIBERNATE;
            IDLE_SLEEP:     nxt_state = ST_SLEEP;
            IDLE_TAG_DET:   nxt_state = ST_TAG_DETECT;
            default:        nxt_state = state_ff;
          endcase
        end else if (state_ff == ST_READY && air_standard_choose_cmd_i) begin
          nxt_state = ST_READER;
        end else if (state_ff == ST_READER && field_off_cmd_i) begin
          nxt_state = ST_READY;
        end
      end
      default:       nxt_state = ST_POWER_UP;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_POWER_UP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      setup_cnt_ff <= '0;
    end else if (state_ff != ST_OSC_SETUP) begin
      setup_cnt_ff <= '0;
    end else if (!setup_done) begin
      setup_cnt_ff <= setup_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      src_en_ff <= '0;
    end else if (idle_ok) begin
      src_en_ff <= idle_src_en_i;
    end
  end

  // arm latch after reset or hibernate
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sel_pending_ff <= 1'b1;
    end else if (idle_ok && idle_target_i == IDLE_HIBERNATE) begin
      sel_pending_ff <= 1'b1;
    end else if (wake_fall && sel_pending_ff) begin
      sel_pending_ff <= 1'b0;
    end
  end

  wire [1:0] sel_iface = (!sel0_s_ff[1] && !sel1_s_ff[1]) ? IFACE_UART :
                         ( sel0_s_ff[1] && !sel1_s_ff[1]) ? IFACE_SPI  :
                                                            IFACE_NONE;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      iface_o <= IFACE_NONE;
    end else if (wake_fall && sel_pending_ff) begin
      iface_o <= sel_iface;
    end
  end

  // hold receiver off until wake pin idles high
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      uart_gate_ff <= 1'b0;
    end else if (nxt_state == ST_READY || nxt_state == ST_READER) begin
      uart_gate_ff <= uart_gate_ff || !wake_low;
    end else begin
      uart_gate_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rf_on_ff           <= 1'b0;
      state_o            <= 3'h0;
      wait_event_group_o <= 1'b1;
      slow_oscillator_o  <= 1'b1;
      fast_oscillator_o  <= 1'b0;
      host_comm_en_o     <= 1'b0;
    end else begin
      rf_on_ff           <= (nxt_state == ST_READER);
      state_o            <= nxt_state;
      wait_event_group_o <= in_wait_group;
      slow_oscillator_o  <= slow_run;
      fast_oscillator_o  <= !in_wait_group;
      // no host traffic in wait group
      host_comm_en_o     <= (nxt_state == ST_READY) ||
                            (nxt_state == ST_READER);
    end
  end

  assign rf_field_on_o  = rf_on_ff;
  assign uart_rx_gate_o = uart_gate_ff;
  assign src_en_o       = src_en_ff;
endmodule : wake_power_ctrl

// ### rtl/wake_ctrl_pkg.sv
// constants and types shared by the wake and power state controller
package wake_ctrl_pkg;
  localparam int unsigned CLK_HZ         = 40_000_000;
  // wake pulse on the wake input must exceed this width
  localparam int unsigned WAKE_MIN_NS    = 10_000;
  // slow oscillator period, default
  localparam int unsigned SLOW_DIV       = 40;
  // least wake width in slow periods, rounded up
  localparam int unsigned WAKE_MIN_TICKS =
    (WAKE_MIN_NS * (CLK_HZ / 1_000_000) / 1000 + SLOW_DIV - 1) / SLOW_DIV;
  // fast oscillator setup time before Ready, 10 ms
  localparam int unsigned FAST_SETUP_US  = 10_000;
  localparam int unsigned FAST_SETUP_CYC =
    FAST_SETUP_US * (CLK_HZ / 1_000_000);
  // idle command: wake source enable bit positions
  localparam int unsigned SRC_TIMER      = 0;
  localparam int unsigned SRC_WAKE_PIN   = 1;
  localparam int unsigned SRC_SEL_PIN    = 2;
  localparam int unsigned SRC_TAG        = 3;
  localparam int unsigned SRC_W          = 4;
  // idle command target state codes
  localparam logic [1:0] IDLE_HIBERNATE  = 2'h0;
  localparam logic [1:0] IDLE_SLEEP      = 2'h1;
  localparam logic [1:0] IDLE_TAG_DET    = 2'h2;
  // host interface encoding
  localparam logic [1:0] IFACE_NONE      = 2'h0;
  localparam logic [1:0] IFACE_UART      = 2'h1;
  localparam logic [1:0] IFACE_SPI       = 2'h2;
  typedef enum logic [2:0] {
    ST_POWER_UP,
    ST_HIBERNATE,
    ST_SLEEP,
    ST_TAG_DETECT,
    ST_OSC_SETUP,
    ST_READY,
    ST_READER
  } pwr_state_t;
endpackage : wake_ctrl_pkg

// ### rtl/wake_pulse_qual.sv
// slow tick divider and low-level width qualifier for the wake input
`timescale 1ns/1ps
module wake_pulse_qual #(
  parameter int unsigned DIV   = 40,
  parameter int unsigned TICKS = 10
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  input  wire logic wake_low_i,
  output logic      slow_tick_o,
  output logic      wake_ok_o
);
  localparam int unsigned DW = $clog2(DIV + 1);
  localparam int unsigned TW = $clog2(TICKS + 2);
  logic [DW-1:0] div_ff;
  logic [TW-1:0] low_cnt_ff;
  wire           div_end  = (div_ff == DW'(DIV - 1));
  wire           cnt_full = (low_cnt_ff > TW'(TICKS));

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff      <= '0;
      slow_tick_o <= 1'b0;
    end else begin
      div_ff      <= (!run_i || div_end) ? '0 : div_ff + 1'b1;
      slow_tick_o <= run_i && div_end;
    end
  end

  // counting slow periods keeps the check alive with fast clock gated
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt_ff <= '0;
    end else if (!run_i || !wake_low_i) begin
      low_cnt_ff <= '0;
    end else if (slow_tick_o && !cnt_full) begin
      low_cnt_ff <= low_cnt_ff + 1'b1;
    end
  end

  // strictly longer than the minimum before a wake is accepted
  assign wake_ok_o = cnt_full && !wake_low_i;
endmodule : wake_pulse_qual

// ### verif/wake_power_ctrl_checker.sv
// port assertions for the wake and power state controller
`timescale 1ns/1ps
module wake_power_ctrl_checker
  import wake_ctrl_pkg::*;
#(
  parameter int unsigned SETUP_CYC = FAST_SETUP_CYC
) (
  input wire logic       clk_sys_i,
  input wire logic       nrst_i,
  input wire logic       wake_rx_i,
  input wire logic       tag_detected_i,
  input wire logic       idle_cmd_i,
  input wire logic       air_standard_choose_cmd_i,
  input wire logic [2:0] state_o,
  input wire logic       wait_event_group_o,
  input wire logic       rf_field_on_o,
  input wire logic       host_comm_en_o,
  input wire logic       uart_rx_gate_o,
  input wire logic [1:0] iface_o,
  input wire logic [3:0] src_en_o
);
  // exit edge may fall one cycle either side of the count
  localparam int LO = int'(SETUP_CYC) - 1;
  localparam int HI = int'(SETUP_CYC) + 1;
  // state codes follow the package enum order
  logic [31:0] osc_cnt_ff;
  always_ff @(posedge clk_sys_i or negedge nrst_i)
    if (!nrst_i) osc_cnt_ff <= '0;
    else osc_cnt_ff <= (state_o == 3'd4) ? osc_cnt_ff + 32'h0000_0001 : '0;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence tag_seen_s;
    (state_o == 3'd3 && src_en_o[SRC_TAG] && tag_detected_i) [*3];
  endsequence
  group_flag_a: assert property (
    wait_event_group_o == ($past(state_o) <= 3'd3))
    else $error("wait group flag wrong");
  rf_off_a: assert property (
    state_o != 3'd6 && $past(state_o) != 3'd6 |-> !rf_field_on_o)
    else $error("field on outside reader");
  idle_entry_a: assert property (
    state_o inside {[3'd1:3'd3]} && $past(state_o) >= 3'd5
    |-> $past(idle_cmd_i) || $past(idle_cmd_i, 2))
    else $error("low power entry without idle command");
  setup_exit_a: assert property (
    $past(state_o) == 3'd4 && state_o != 3'd4
    |-> state_o == 3'd5 && osc_cnt_ff inside {[LO:HI]})
    else $error("setup delay wrong");
  iface_hold_a: assert property (
    $changed(iface_o) |-> $past(state_o) <= 3'd1)
    else $error("interface changed outside latch");
  gate_after_a: assert property (
    $rose(uart_rx_gate_o) |-> host_comm_en_o && $past(wake_rx_i, 3))
    else $error("receiver enabled during wake pulse");
  tag_wake_a: assert property (
    tag_seen_s |-> ##[1:6] state_o == 3'd4)
    else $error("no wake on enabled tag");
  reader_go_a: assert property (
    state_o == 3'd5 && air_standard_choose_cmd_i |-> ##[1:2] state_o == 3'd6)
    else $error("no reader entry");
endmodule : wake_power_ctrl_checker

// ### verif/host_mcu_model.sv
// host side model driving the wake, select and strap pins
`timescale 1ns/1ps
module host_mcu_model (
  input  wire logic clk_sys_i,
  output logic      wake_rx_o,
  output logic      slave_sel_n_o,
  output logic      sel0_o,
  output logic      sel1_o
);
  // pulled-up pins rest high; straps start at UART
  initial {wake_rx_o, slave_sel_n_o, sel1_o, sel0_o} = 4'hc;
  task automatic straps(input logic [1:0] v);
    {sel1_o, sel0_o} = v;
  endtask : straps
  task automatic low(input logic ss, input int n);
    if (ss) slave_sel_n_o = 1'b0;
    else wake_rx_o = 1'b0;
    repeat (n) @(posedge clk_sys_i);
    #2 {wake_rx_o, slave_sel_n_o} = 2'h3;
  endtask : low
endmodule : host_mcu_model

// ### verif/wake_power_ctrl_tb.sv
// self-checking bench for the wake and power state controller
`timescale 1ns/1ps
module wake_power_ctrl_tb
  import wake_ctrl_pkg::*;
;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, tag_detected_i = 1'b0;
  logic timer_expired_i = 1'b0, idle_cmd_i = 1'b0, field_off_cmd_i = 1'b0;
  logic air_standard_choose_cmd_i = 1'b0;
  logic [1:0] idle_target_i = '0;
  logic [SRC_W-1:0] idle_src_en_i = '0;
  wire logic wake_rx_i, slave_sel_n_i, iface_sel_bit0_i, iface_sel_bit1_i;
  logic [2:0] state_o;
  logic wait_event_group_o, slow_oscillator_o, rf_field_on_o;
  logic fast_oscillator_o;
  logic host_comm_en_o, uart_rx_gate_o;
  logic [1:0] iface_o;
  logic [SRC_W-1:0] src_en_o;
  logic [2:0] exp_q[$];
  logic [15:0] rnd = 16'hdaf7;
  int n_errors = 0;
  int samples_checked = 0;
  // short setup so the run stays brief
  wake_power_ctrl #(.SETUP_CYC(20)) wake_power_ctrl_i (
    .clk_sys_i, .nrst_i, .wake_rx_i, .slave_sel_n_i, .iface_sel_bit0_i,
    .iface_sel_bit1_i, .tag_detected_i, .timer_expired_i, .idle_cmd_i,
    .idle_target_i, .idle_src_en_i, .air_standard_choose_cmd_i,
    .field_off_cmd_i, .state_o, .wait_event_group_o, .slow_oscillator_o,
    .fast_oscillator_o, .rf_field_on_o, .host_comm_en_o, .uart_rx_gate_o,
    .iface_o, .src_en_o);
  host_mcu_model host_mcu_model_i (.clk_sys_i, .wake_rx_o(wake_rx_i),
    .slave_sel_n_o(slave_sel_n_i), .sel0_o(iface_sel_bit0_i),
    .sel1_o(iface_sel_bit1_i));
  always #12.5 clk_sys_i = ~clk_sys_i;
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    n_errors++;
    wrap_up();
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse
  task automatic idle(input logic [1:0] t, input logic [3:0] e);
    idle_target_i = t;
    idle_src_en_i = e;
    pulse(idle_cmd_i);
  endtask : idle
  task automatic wait_st(input logic [2:0] s);
    repeat (100) if (state_o !== s) cyc(1);
  endtask : wait_st
  task automatic wrap_up();
    if (exp_q.size() != 0) n_errors++;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // each state change is matched against the oldest note
  always @(state_o)
    if (nrst_i === 1'b1)
      chk(4'(state_o),
          exp_q.size() > 0 ? 4'(exp_q.pop_front()) : 4'hf);
  initial begin
    repeat (6) @(posedge clk_sys_i);
    #2 nrst_i = 1'b1;
    cyc(3);
    chk(4'(state_o), 4'h0);
    chk(4'(slow_oscillator_o), 4'h1);
    chk(4'(wait_event_group_o), 4'h1);
    chk(4'(fast_oscillator_o), 4'h0);
    idle(IDLE_SLEEP, 4'h4);
    cyc(4);
    chk(4'(state_o), 4'h0);
    $display("test 1 done");
    rnd = lfsr(rnd);
    host_mcu_model_i.straps(2'b01);
    host_mcu_model_i.low(1'b0, 40 + int'(rnd[7:0]));
    cyc(20);
    chk(4'(state_o), 4'h0);
    $display("test 2 done");
    // append, so a state the design skipped is still counted at the end
    exp_q = {exp_q, 3'd4, 3'd5};
    host_mcu_model_i.low(1'b0, 480);
    wait_st(3'd5);
    cyc(3);
    chk(4'(iface_o), 4'(IFACE_SPI));
    chk(4'(host_comm_en_o), 4'h1);
    chk(4'(rf_field_on_o), 4'h0);
    chk(4'(uart_rx_gate_o), 4'h1);
    chk(4'(fast_oscillator_o), 4'h1);
    chk(4'(wait_event_group_o), 4'h0);
    exp_q = {exp_q, 3'd6, 3'd5};
    pulse(air_standard_choose_cmd_i);
    cyc(4);
    chk(4'(rf_field_on_o), 4'h1);
    chk(4'(host_comm_en_o), 4'h1);
    pulse(field_off_cmd_i);
    cyc(4);
    chk(4'(rf_field_on_o), 4'h0);
    $display("test 3 done");
    exp_q = {exp_q, 3'd2, 3'd4, 3'd5};
    idle(IDLE_SLEEP, 4'h4);
    cyc(4);
    chk(4'(slow_oscillator_o), 4'h1);
    chk(4'(fast_oscillator_o), 4'h0);
    idle(IDLE_HIBERNATE, 4'h1);
    cyc(4);
    chk(4'(host_comm_en_o), 4'h0);
    chk(src_en_o, 4'h4);
    host_mcu_model_i.low(1'b1, 20);
    wait_st(3'd5);
    chk(4'(iface_o), 4'(IFACE_SPI));
    exp_q = {exp_q, 3'd2, 3'd4, 3'd5};
    idle(IDLE_SLEEP, 4'h1);
    cyc(4);
    pulse(timer_expired_i);
    wait_st(3'd5);
    exp_q = {exp_q, 3'd2, 3'd4, 3'd5};
    idle(IDLE_SLEEP, 4'h2);
    cyc(4);
    // pin still low when Ready is reached: receiver must stay shut
    fork
      host_mcu_model_i.low(1'b0, 40);
      begin
        wait_st(3'd5);
        chk(4'(uart_rx_gate_o), 4'h0);
      end
    join
    cyc(4);
    chk(4'(uart_rx_gate_o), 4'h1);
    $display("test 4 done");
    exp_q = {exp_q, 3'd3, 3'd4, 3'd5};
    idle(IDLE_TAG_DET, 4'h8);
    cyc(4);
    pulse(timer_expired_i);
    cyc(4);
    chk(4'(state_o), 4'h3);
    tag_detected_i = 1'b1;
    wait_st(3'd4);
    tag_detected_i = 1'b0;
    wait_st(3'd5);
    $display("test 5 done");
    exp_q = {exp_q, 3'd1, 3'd4, 3'd5};
    idle(IDLE_HIBERNATE, 4'hf);
    host_mcu_model_i.straps(2'b00);
    {tag_detected_i, timer_expired_i} = rnd[1:0] | 2'b01;
    host_mcu_model_i.low(1'b1, 30);
    chk(4'(state_o), 4'h1);
    chk(4'(wait_event_group_o), 4'h1);
    chk(4'(fast_oscillator_o), 4'h0);
    {tag_detected_i, timer_expired_i} = 2'b00;
    // let an edge pass so the pins are not assigned twice in one step
    cyc(1);
    host_mcu_model_i.low(1'b0, 480);
    wait_st(3'd5);
    chk(4'(iface_o), 4'(IFACE_UART));
    $display("test 6 done");
    wrap_up();
  end
endmodule : wake_power_ctrl_tb
bind wake_power_ctrl wake_power_ctrl_checker #(.SETUP_CYC(SETUP_CYC))
  wake_power_ctrl_checker_i (.clk_sys_i, .nrst_i, .wake_rx_i,
  .tag_detected_i, .idle_cmd_i, .air_standard_choose_cmd_i, .state_o,
  .wait_event_group_o, .rf_field_on_o, .host_comm_en_o, .uart_rx_gate_o,
  .iface_o, .src_en_o);
